// >>> rtl/vdb_pkg.sv
// shared constants and types for the code decoder and current balance block
package vdb_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_AVG = 8'h0c;
	localparam logic [7:0] ADDR_ERR1 = 8'h10;
	localparam logic [7:0] ADDR_ERR2 = 8'h14;

	// control fields: enable, filter shift, correction gain shift
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_FILT_LSB = 1;
	localparam int CTRL_FILT_W = 3;
	localparam int CTRL_GAIN_LSB = 4;
	localparam int CTRL_GAIN_W = 4;
	localparam logic [7:0] CTRL_RST = 8'h05;

	// status fields
	localparam int STAT_OFF_BIT = 16;
	localparam int STAT_SINGLE_BIT = 17;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int SYS_CLK_HZ = 250_000_000;
	localparam int FSW_DEFAULT_HZ = 1_000_000;
	localparam logic [15:0] PERIOD_RST = 16'(SYS_CLK_HZ / FSW_DEFAULT_HZ);
	localparam logic [15:0] PERIOD_MIN = 16'h000c;
	localparam int NCH = 2;

	// ************************************************************
	// code tables, setpoint in units of 0.1 mV
	// ************************************************************
	typedef enum logic [1:0] {TBL_SIX, TBL_FIRST, TBL_LOW} vdb_table_t;
	localparam logic [15:0] SP_BASE_LOW = 16'h1f40;
	localparam logic [15:0] SP_BASE_FIRST = 16'h2af8;
	localparam logic [15:0] SP_BASE_SIX = 16'h20b7;
	localparam logic [15:0] SP_STEP5 = 16'h00fa;
	localparam logic [15:0] SP_STEP6 = 16'h007d;
	localparam logic [4:0] CODE5_TOP = 5'h1e;
	localparam logic [4:0] CODE5_OFF = 5'h1f;
	localparam logic [5:0] CODE6_ANCHOR = 6'h14;
	localparam logic [5:0] CODE6_SKIP = 6'h02;

endpackage : vdb_pkg

// >>> rtl/vdb_code_decoder.sv
// reference code decoder: code and table to setpoint and off flag
`timescale 1ns/1ps
module vdb_code_decoder (
	input wire logic [4:0] code_in, // voltage code bits 4..0
	input wire logic range_bit, // range select level, lsb in six-bit table
	input wire logic [1:0] table_sel, // active code table
	output logic [15:0] setpoint, // reference setpoint, 0.1 mV units
	output logic off // reserved code or unused table select, output off
);

	logic [5:0] code6;
	logic [5:0] idx6;

	// ************************************************************
	// purely combinational decode
	// ************************************************************
	assign code6 = {code_in, range_bit};

	// six-bit index counts 12.5 mV steps up from the lowest code
	always_comb begin
		idx6 = 6'(vdb_pkg::CODE6_ANCHOR - code6);
		if (code6 > vdb_pkg::CODE6_ANCHOR) begin
			idx6 = 6'(idx6 - vdb_pkg::CODE6_SKIP); // hop over the two off codes
		end
	end

	// table lookup by formula [RULE_07] [RULE_15]
	always_comb begin
		setpoint = 16'h0000;
		off = 1'b1;
		case (vdb_pkg::vdb_table_t'(table_sel)) // [RULE_08]
			vdb_pkg::TBL_LOW: begin
				if (code_in != vdb_pkg::CODE5_OFF) begin // [RULE_09] [RULE_14]
					off = 1'b0;
					setpoint = 16'(vdb_pkg::SP_BASE_LOW
						+ 16'(vdb_pkg::CODE5_TOP - code_in) * vdb_pkg::SP_STEP5);
				end
			end
			vdb_pkg::TBL_FIRST: begin
				if (code_in != vdb_pkg::CODE5_OFF) begin // [RULE_10] [RULE_14]
					off = 1'b0;
					setpoint = 16'(vdb_pkg::SP_BASE_FIRST
						+ 16'(vdb_pkg::CODE5_TOP - code_in) * vdb_pkg::SP_STEP5);
				end
			end
			vdb_pkg::TBL_SIX: begin
				if (code_in != vdb_pkg::CODE5_OFF) begin // [RULE_11] [RULE_14]
					off = 1'b0;
					setpoint = 16'(vdb_pkg::SP_BASE_SIX + 16'(idx6) * vdb_pkg::SP_STEP6);
				end
			end
			default: begin
				setpoint = 16'h0000; // unused select code forces output off
				off = 1'b1;
			end
		endcase
	end

endmodule : vdb_code_decoder

// >>> rtl/vdb_balance_top.sv
// two-leg pulse sequencer with current sampling, balance and code decoding
// Contract
// RULE_01: each cycle average active channel samples
// RULE_02: trim pulse width by filtered balance error
// RULE_03: window opens one sixth period after fall
// RULE_04: window stays open until rise; hold
// RULE_05: held samples feed only the balance
// RULE_06: per-channel copies; leg two off when single
// RULE_07: decode five or six bit code
// RULE_08: range select picks the code table
// RULE_09: low table: 0.800 to 1.550, ones off
// RULE_10: first table: 1.100 to 1.850, ones off
// RULE_11: six-bit: range bit is lsb, 0.8375
// RULE_12: hold pulse low one third cycle
// RULE_13: board straps both leg-two pins high
// RULE_14: explicit off flag for all-ones codes
// RULE_15: setpoint decoded purely combinationally
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module vdb_balance_top #(
	parameter int SENSE_W = 12 // width of a channel current sample
) (
	input wire logic SYS_CLK, // system clock, 250 MHz
	input wire logic RST, // synchronous reset, active high
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb access phase
	input wire logic PWRITE, // apb direction, high for write
	input wire logic [7:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready, always high
	output logic PSLVERR, // apb error on unmapped address
	input wire logic [4:0] VOLTAGE_CODE_INPUTS, // code from the processor
	input wire logic RANGE_SELECT_INPUT, // range select level bit
	input wire logic [1:0] TABLE_SELECT, // decoded range select condition
	input wire logic [15:0] ERROR_AMP_LEVEL, // commanded on time in clocks
	input wire logic [SENSE_W-1:0] CHANNEL_CURRENT_SENSE_1, // leg one current
	input wire logic [SENSE_W-1:0] CHANNEL_CURRENT_SENSE_2, // leg two current
	input wire logic LEG2_BOOTSTRAP_PIN, // high when tied to supply
	input wire logic LEG2_SWITCH_NODE_PIN, // high when tied to supply
	output logic LEG1_PULSE, // leg one pulse output
	output logic LEG2_PULSE, // leg two pulse output
	output logic [15:0] REFERENCE_SETPOINT, // decoded setpoint, 0.1 mV
	output logic OUTPUT_OFF, // reserved code or unused table select seen
	output logic [SENSE_W-1:0] CYCLE_AVERAGE_CURRENT // latest cycle average
);

	// ************************************************************
	// declarations
	// ************************************************************
	localparam int EW = SENSE_W + 1;
	localparam int AW = SENSE_W + 4;

	logic [7:0] ctrl_ff;
	logic [15:0] period_ff;
	logic [31:0] prdata_ff;
	logic single_ff;
	logic [15:0] cnt_ff;
	logic [SENSE_W-1:0] avg_ff;
	logic [SENSE_W-1:0] nxt_avg;
	logic [15:0] period_eff;
	logic [15:0] half;
	logic [15:0] sixth;
	logic [15:0] third_up;
	logic run;
	logic [2:0] filt_sh;
	logic [3:0] gain_sh;
	logic [15:0] setpoint;
	logic off;
	logic wr_en;
	logic setup_rd;
	logic [SENSE_W-1:0] sense [vdb_pkg::NCH];
	logic [SENSE_W-1:0] held [vdb_pkg::NCH];
	logic [EW-1:0] err [vdb_pkg::NCH];
	logic pulse [vdb_pkg::NCH];

	// ************************************************************
	// register bus helpers
	// ************************************************************
	// true for any mapped word address
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == vdb_pkg::ADDR_CTRL) || (a == vdb_pkg::ADDR_PERIOD)
			|| (a == vdb_pkg::ADDR_STATUS) || (a == vdb_pkg::ADDR_AVG)
			|| (a == vdb_pkg::ADDR_ERR1) || (a == vdb_pkg::ADDR_ERR2);
	endfunction : addr_hit

	// sign extend a balance error to a full word
	function automatic logic [31:0] ext_err(input logic [EW-1:0] e);
		ext_err = 32'(signed'(e));
	endfunction : ext_err

	assign wr_en = PSEL && PENABLE && PWRITE && addr_hit(PADDR);
	assign setup_rd = PSEL && !PENABLE && !PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !addr_hit(PADDR);
	assign PRDATA = prdata_ff;

	// control register
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ctrl_ff <= vdb_pkg::CTRL_RST;
		end else if (wr_en && PADDR == vdb_pkg::ADDR_CTRL) begin
			ctrl_ff <= PWDATA[7:0];
		end
	end

	// switching period register, in system clocks
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			period_ff <= vdb_pkg::PERIOD_RST;
		end else if (wr_en && PADDR == vdb_pkg::ADDR_PERIOD) begin
			period_ff <= PWDATA[15:0];
		end
	end

	// read data captured in the setup phase, valid through the access phase
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup_rd) begin
			case (PADDR)
				vdb_pkg::ADDR_CTRL: prdata_ff <= {24'h00_0000, ctrl_ff};
				vdb_pkg::ADDR_PERIOD: prdata_ff <= {16'h0000, period_ff};
				vdb_pkg::ADDR_STATUS: prdata_ff <= {14'h0000, single_ff, off, setpoint};
				vdb_pkg::ADDR_AVG: prdata_ff <= 32'(avg_ff);
				vdb_pkg::ADDR_ERR1: prdata_ff <= ext_err(err[0]);
				vdb_pkg::ADDR_ERR2: prdata_ff <= ext_err(err[1]);
				default: prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// reference decoder
	// ************************************************************
	vdb_code_decoder u_decoder (
		.code_in(VOLTAGE_CODE_INPUTS),
		.range_bit(RANGE_SELECT_INPUT),
		.table_sel(TABLE_SELECT),
		.setpoint(setpoint),
		.off(off)
	);

	assign REFERENCE_SETPOINT = setpoint; // combinational on purpose [RULE_15]
	assign OUTPUT_OFF = off; // [RULE_14]

	// ************************************************************
	// channel count and cycle timing
	// ************************************************************
	// strap is caught while reset is held; both pins high means one leg
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			single_ff <= LEG2_BOOTSTRAP_PIN && LEG2_SWITCH_NODE_PIN; // [RULE_06] [RULE_13]
		end
	end

	// derived fractions of the period; tiny periods are clamped
	assign period_eff = (period_ff < vdb_pkg::PERIOD_MIN) ? vdb_pkg::PERIOD_MIN : period_ff;
	assign half = period_eff >> 1;
	assign sixth = 16'(period_eff / 16'h0006);
	assign third_up = 16'((17'(period_eff) + 17'h0_0002) / 17'h0_0003);
	assign run = ctrl_ff[vdb_pkg::CTRL_EN_BIT] && !off;
	assign filt_sh = ctrl_ff[vdb_pkg::CTRL_FILT_LSB +: vdb_pkg::CTRL_FILT_W];
	assign gain_sh = ctrl_ff[vdb_pkg::CTRL_GAIN_LSB +: vdb_pkg::CTRL_GAIN_W];

	// cycle counter; zero marks the leg one termination
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			cnt_ff <= 16'h0000;
		end else if (cnt_ff >= period_eff - 16'h0001) begin
			cnt_ff <= 16'h0000;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	// ************************************************************
	// cycle average
	// ************************************************************
	// sum the active samples and divide by the active count
	always_comb begin
		if (single_ff) begin
			nxt_avg = held[0];
		end else begin
			nxt_avg = SENSE_W'(({1'b0, held[0]} + {1'b0, held[1]}) >> 1);
		end
	end

	// average refreshed once per cycle at leg one termination
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			avg_ff <= '0;
		end else if (cnt_ff == 16'h0000) begin
			avg_ff <= nxt_avg; // [RULE_01]
		end
	end

	assign CYCLE_AVERAGE_CURRENT = avg_ff;
	assign sense[0] = CHANNEL_CURRENT_SENSE_1;
	assign sense[1] = CHANNEL_CURRENT_SENSE_2;
	assign LEG1_PULSE = pulse[0];
	assign LEG2_PULSE = pulse[1];

	// ************************************************************
	// per-channel sampling, balance and pulse logic
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < vdb_pkg::NCH; gi = gi + 1) begin : g_leg
			logic [15:0] ph;
			logic [16:0] ph_raw;
			logic active;
			logic term;
			logic rise;
			logic close;
			logic pulse_ff;
			logic cut_ff;
			logic open_ff;
			logic [SENSE_W-1:0] held_ff;
			logic [AW-1:0] acc_ff;
			logic [AW-1:0] diff;
			logic [AW-1:0] corr;
			logic signed [17:0] width_s;
			logic [15:0] width;
			logic [15:0] max_width;

			// leg phase: leg two trails leg one by half a period
			assign ph_raw = (gi == 0) ? 17'(cnt_ff)
				: ((cnt_ff >= half) ? 17'(cnt_ff - half)
				: 17'(cnt_ff) + 17'(period_eff) - 17'(half));
			assign ph = ph_raw[15:0];
			assign active = (gi == 0) || !single_ff; // [RULE_06]
			assign term = (ph == 16'h0000);

			// commanded on time minus correction, limited by the forced off time
			assign corr = AW'(signed'(acc_ff) >>> gain_sh);
			assign width_s = 18'(signed'({2'b00, ERROR_AMP_LEVEL}))
				- 18'(signed'(corr)); // [RULE_02]
			assign max_width = period_eff - third_up;
			always_comb begin
				if (width_s <= 18'sh0_0000) begin
					width = 16'h0000;
				end else if (width_s > 18'(signed'({2'b00, max_width}))) begin
					width = max_width;
				end else begin
					width = width_s[15:0];
				end
			end

			// rise once the forced off time is over and the ramp is crossed
			assign rise = run && active && !pulse_ff && !term && !cut_ff
				&& (width != 16'h0000)
				&& (ph >= third_up) // [RULE_12]
				&& (ph >= period_eff - width);

			// pulse output: falls at termination, rises on the crossing
			always_ff @(posedge SYS_CLK) begin
				if (RST) begin
					pulse_ff <= 1'b0;
				end else if (!run || !active || term) begin
					pulse_ff <= 1'b0;
				end else if (rise) begin
					pulse_ff <= 1'b1;
				end
			end

			// pulse cut by disable stays low to the next termination, keeping the off time
			always_ff @(posedge SYS_CLK) begin
				if (RST || term) begin
					cut_ff <= 1'b0;
				end else if (pulse_ff && (!run || !active)) begin
					cut_ff <= 1'b1; // [RULE_12]
				end
			end

			// window opens a sixth period after the fall, closes on rise or end
			assign close = open_ff && (rise || term); // [RULE_04]
			always_ff @(posedge SYS_CLK) begin
				if (RST || !active) begin
					open_ff <= 1'b0;
				end else if (close) begin
					open_ff <= 1'b0;
				end else if (ph == sixth && !pulse_ff) begin
					open_ff <= 1'b1; // [RULE_03]
				end
			end

			// sample taken at window close and held until the next close
			always_ff @(posedge SYS_CLK) begin
				if (RST || !active) begin
					held_ff <= '0;
				end else if (close) begin
					held_ff <= sense[gi]; // [RULE_04]
				end
			end

			// error against the cycle average, low-pass filtered per cycle
			assign err[gi] = EW'({1'b0, held_ff}) - EW'({1'b0, avg_ff}); // [RULE_02]
			assign diff = AW'(signed'(err[gi])) - acc_ff;
			always_ff @(posedge SYS_CLK) begin
				if (RST || !active) begin
					acc_ff <= '0;
				end else if (cnt_ff == 16'h0001) begin
					acc_ff <= acc_ff + AW'(signed'(diff) >>> filt_sh);
				end
			end

			// held samples leave only toward average and error [RULE_05]
			assign held[gi] = held_ff;
			assign pulse[gi] = pulse_ff;
		end
	endgenerate

endmodule : vdb_balance_top

// >>> verification/vdb_properties.sv
// checker of code decoding, pulse timing and bus answers
`timescale 1ns/1ps
module vdb_properties (
	input wire logic SYS_CLK, // clock
	input wire logic RST, // reset
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb access
	input wire logic [7:0] PADDR, // apb address
	input wire logic PREADY, // apb ready
	input wire logic PSLVERR, // apb error
	input wire logic [4:0] VOLTAGE_CODE_INPUTS, // code
	input wire logic RANGE_SELECT_INPUT, // range bit
	input wire logic [1:0] TABLE_SELECT, // table
	input wire logic LEG2_BOOTSTRAP_PIN, // strap
	input wire logic LEG2_SWITCH_NODE_PIN, // strap
	input wire logic LEG1_PULSE, // leg one
	input wire logic LEG2_PULSE, // leg two
	input wire logic [15:0] REFERENCE_SETPOINT, // setpoint
	input wire logic OUTPUT_OFF // off flag
);
	logic single_ff;
	logic [4:0] c;
	// ************
	// properties
	// ************
	// strap copy taken while reset is high
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			single_ff <= LEG2_BOOTSTRAP_PIN & LEG2_SWITCH_NODE_PIN;
		end
	end
	assign c = VOLTAGE_CODE_INPUTS;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	sequence s_fall1;
		$fell(LEG1_PULSE);
	endsequence
	sequence s_low4;
		!LEG1_PULSE [*4];
	endsequence
	property p_min_off;
		s_fall1 |-> s_low4;
	endproperty
	property p_low;
		TABLE_SELECT == 2'h2 && c != 5'h1f |->
			REFERENCE_SETPOINT == 16'h1f40 + 16'(5'h1e - c) * 16'h00fa && !OUTPUT_OFF;
	endproperty
	property p_first;
		TABLE_SELECT == 2'h1 && c != 5'h1f |->
			REFERENCE_SETPOINT == 16'h2af8 + 16'(5'h1e - c) * 16'h00fa && !OUTPUT_OFF;
	endproperty
	property p_ones_off;
		c == 5'h1f |-> OUTPUT_OFF;
	endproperty
	property p_six;
		TABLE_SELECT == 2'h0 && {c, RANGE_SELECT_INPUT} == 6'h14 |->
			REFERENCE_SETPOINT == 16'h20b7 && !OUTPUT_OFF;
	endproperty
	property p_single;
		single_ff |-> !LEG2_PULSE;
	endproperty
	property p_rise_on;
		$rose(LEG1_PULSE) |-> !$past(OUTPUT_OFF);
	endproperty
	property p_bad_addr;
		PSEL && PENABLE && PADDR > 8'h14 |-> PSLVERR && PREADY;
	endproperty
	a_min_off: assert property (p_min_off) else $error("leg one rose too soon");
	a_low: assert property (p_low) else $error("low table value wrong");
	a_first: assert property (p_first) else $error("first table value wrong");
	a_ones_off: assert property (p_ones_off) else $error("all ones not off");
	a_six: assert property (p_six) else $error("six bit anchor wrong");
	a_single: assert property (p_single) else $error("leg two pulsed alone");
	a_rise_on: assert property (p_rise_on) else $error("pulse while off");
	a_bad_addr: assert property (p_bad_addr) else $error("no error on bad address");
endmodule : vdb_properties

// >>> verification/vdb_vid_source.sv
// processor model driving the code pins and the board straps
`timescale 1ns/1ps
module vdb_code_source (
	input wire logic clk, // system clock
	input wire logic [4:0] want_code, // requested code
	input wire logic want_range, // requested range level
	input wire logic [1:0] want_table, // requested range condition
	input wire logic want_single, // single leg board wanted
	output logic [4:0] code_ff, // code pins
	output logic range_ff, // range pin
	output logic [1:0] table_ff, // range condition
	output logic boot_ff, // leg two bootstrap strap
	output logic node_ff // leg two switch node strap
);
	// pins start at known levels
	initial begin
		code_ff = 5'h00;
		range_ff = 1'b0;
		table_ff = 2'h1;
		boot_ff = 1'b0;
		node_ff = 1'b0;
	end
	// pins change just after an edge, like a processor port
	always @(posedge clk) begin
		code_ff <= want_code;
		range_ff <= want_range;
		table_ff <= want_table;
		boot_ff <= want_single;
		node_ff <= want_single;
	end
endmodule : vdb_code_source

// >>> verification/vdb_balance_top_bench.sv
// self-checking bench for the decoder and current balance block
`timescale 1ns/1ps
module vdb_balance_top_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, leg1, leg2, off, rng, boot, node;
	logic [4:0] want_code = 5'h00;
	logic want_range = 1'b0;
	logic [1:0] want_table = 2'h1;
	logic want_single = 1'b0;
	logic [4:0] code;
	logic [1:0] tbl;
	logic [15:0] level = 16'h0004;
	logic [11:0] sense1 = 12'h000;
	logic [11:0] sense2 = 12'h000;
	logic [15:0] setp;
	logic [11:0] avg;
	int compares = 0;
	int miscompares = 0;
	int cycles = 0;
	// ************
	// harness
	// ************
	always #2 clk = ~clk;
	vdb_balance_top vdb_balance_top_inst (
		.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.VOLTAGE_CODE_INPUTS(code), .RANGE_SELECT_INPUT(rng), .TABLE_SELECT(tbl),
		.ERROR_AMP_LEVEL(level), .CHANNEL_CURRENT_SENSE_1(sense1),
		.CHANNEL_CURRENT_SENSE_2(sense2), .LEG2_BOOTSTRAP_PIN(boot),
		.LEG2_SWITCH_NODE_PIN(node), .LEG1_PULSE(leg1), .LEG2_PULSE(leg2),
		.REFERENCE_SETPOINT(setp), .OUTPUT_OFF(off), .CYCLE_AVERAGE_CURRENT(avg)
	);
	vdb_code_source vdb_code_source_inst (
		.clk(clk), .want_code(want_code), .want_range(want_range), .want_table(want_table),
		.want_single(want_single), .code_ff(code), .range_ff(rng), .table_ff(tbl),
		.boot_ff(boot), .node_ff(node)
	);
	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			$display("[ERR] %0t run did not finish", $time);
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		cmp(q, exp);
	endtask : rd
	task automatic set_code(input logic [4:0] c, input logic r, input logic [1:0] t);
		@(posedge clk);
		want_code <= c;
		want_range <= r;
		want_table <= t;
		@(posedge clk);
		#1;
	endtask : set_code
	task automatic do_reset(input logic s);
		@(posedge clk);
		want_single <= s;
		repeat (2) @(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset
	task automatic wait_leg1(input logic v);
		int n;
		n = 0;
		while (leg1 !== v && n < 600) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp({31'h0, leg1}, {31'h0, v});
	endtask : wait_leg1
	// count the cycles in which each leg is not low; unknown counts as high
	task automatic count_legs(input int len, output int n1, output int n2);
		n1 = 0;
		n2 = 0;
		repeat (len) begin
			@(posedge clk);
			#1;
			n1 += (leg1 !== 1'b0);
			n2 += (leg2 !== 1'b0);
		end
	endtask : count_legs
	// ************
	// scenarios
	// ************
	task automatic t_regs();
		logic [31:0] q;
		logic e;
		rd(8'h00, 32'h5);
		rd(8'h04, 32'hfa);
		apb(1'b1, 8'h0c, 32'h0fff, q, e);
		rd(8'h0c, 32'h0);
		apb(1'b0, 8'h20, 32'h0, q, e);
		cmp(q, 32'h0);
		cmp({31'h0, e}, 32'h1);
		$display("register test done");
	endtask : t_regs
	task automatic t_tables();
		logic [15:0] b;
		for (int t = 1; t <= 2; t++) begin
			b = (t == 2) ? 16'h1f40 : 16'h2af8;
			for (int c = 0; c < 32; c++) begin
				set_code(5'(c), 1'b0, 2'(t));
				if (c == 31) cmp({31'h0, off}, 32'h1);
				else cmp({15'h0, off, setp}, {16'h0, b + 16'(30 - c) * 16'h00fa});
			end
		end
		set_code(5'h0a, 1'b0, 2'h0);
		cmp({15'h0, off, setp}, 32'h20b7);
		rd(8'h08, 32'h20b7);
		set_code(5'h09, 1'b1, 2'h0);
		cmp({15'h0, off, setp}, 32'h2134);
		set_code(5'h1f, 1'b1, 2'h0);
		cmp({31'h0, off}, 32'h1);
		set_code(5'h1f, 1'b0, 2'h0);
		cmp({31'h0, off}, 32'h1);
		set_code(5'h0a, 1'b0, 2'h3);
		cmp({15'h0, off, setp}, 32'h00010000);
		$display("table test done");
	endtask : t_tables
	task automatic t_single();
		logic [31:0] q;
		logic e;
		set_code(5'h0a, 1'b0, 2'h1);
		do_reset(1'b1);
		apb(1'b1, 8'h04, 32'hc, q, e);
		sense1 <= 12'h064;
		sense2 <= 12'h3e7;
		rd(8'h08, 32'h00023e80);
		repeat (6) begin
			wait_leg1(1'b1);
			@(posedge clk);
			sense1 <= 12'hfff;
			wait_leg1(1'b0);
			@(posedge clk);
			sense1 <= 12'h064;
		end
		cmp({20'h0, avg}, 32'h64);
		rd(8'h10, 32'h0);
		$display("single leg test done");
	endtask : t_single
	task automatic t_two();
		int n1;
		int n2;
		logic [31:0] q;
		logic e;
		do_reset(1'b0);
		apb(1'b1, 8'h04, 32'hc, q, e);
		sense1 <= 12'h060;
		sense2 <= 12'h068;
		repeat (10) begin
			wait_leg1(1'b1);
			wait_leg1(1'b0);
		end
		cmp({20'h0, avg}, 32'h64);
		rd(8'h10, 32'hfffffffc);
		rd(8'h14, 32'h4);
		count_legs(24, n1, n2);
		cmp(32'(n1), 32'h10);
		cmp({31'h0, n1 > n2}, 32'h1);
		$display("two leg test done");
	endtask : t_two
	task automatic t_off();
		int n1;
		int n2;
		logic [31:0] q;
		logic e;
		apb(1'b1, 8'h00, 32'h4, q, e);
		repeat (12) @(posedge clk);
		count_legs(24, n1, n2);
		cmp(32'(n1 + n2), 32'h0);
		apb(1'b1, 8'h00, 32'h5, q, e);
		count_legs(24, n1, n2);
		cmp(32'(n1), 32'h10);
		set_code(5'h1f, 1'b0, 2'h1);
		repeat (12) @(posedge clk);
		count_legs(24, n1, n2);
		cmp(32'(n1 + n2), 32'h0);
		$display("off test done");
	endtask : t_off
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_tables();
		t_single();
		t_two();
		t_off();
		end_of_test();
	end
endmodule : vdb_balance_top_bench
bind vdb_balance_top vdb_properties vdb_properties_inst (
	.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .VOLTAGE_CODE_INPUTS(VOLTAGE_CODE_INPUTS),
	.RANGE_SELECT_INPUT(RANGE_SELECT_INPUT), .TABLE_SELECT(TABLE_SELECT),
	.LEG2_BOOTSTRAP_PIN(LEG2_BOOTSTRAP_PIN), .LEG2_SWITCH_NODE_PIN(LEG2_SWITCH_NODE_PIN),
	.LEG1_PULSE(LEG1_PULSE), .LEG2_PULSE(LEG2_PULSE),
	.REFERENCE_SETPOINT(REFERENCE_SETPOINT), .OUTPUT_OFF(OUTPUT_OFF)
);
